// ---- hw/alu_branch_exec_unit.sv ----
// execution unit for alu, jump, call, compare, skip and branch operations
`timescale 1ns/100ps
`include "alu_exec_regs.svh"
module alu_branch_exec_unit
   import alu_exec_pkg::*;
#(
   parameter int STACK_DEPTH = 16
)
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        start_in,      // issue one instruction
   input  wire instr_t      instr_in,
   output logic             busy_out,      // multi-cycle instruction in progress after issue
   output logic             done_out,      // one-cycle pulse at completion
   output result_t          result_out,    // register write-back
   output logic      [7:0]  flags_out,     // status_flags_reg
   output logic      [15:0] pc_out,
   output logic             stack_err_out  // overflow or underflow of return stack
);
   localparam int SP_W = $clog2(STACK_DEPTH);

   // refuse depths that the pointer width or the full test cannot serve
   if (STACK_DEPTH < 2 || STACK_DEPTH > 256)
   begin : depth_check_g
      $error("STACK_DEPTH must lie between 2 and 256");
   end

   typedef enum logic [1:0] {st_idle, st_wait} state_t;

   state_t           state_r;
   logic      [2:0]  cnt_r;
   logic      [15:0] pc_r;
   logic      [7:0]  flags_r;
   result_t          result_r;
   logic             busy_r;
   logic             done_r;
   logic             err_r;
   logic      [15:0] stack_mem [STACK_DEPTH];
   logic [SP_W:0]    sp_r;

   logic      [7:0]  alu_res;
   logic      [7:0]  alu_flags;
   logic             alu_wr;
   logic      [2:0]  cycles;
   logic      [15:0] target;
   logic             skip;
   logic      [16:0] word_sum;
   logic      [15:0] pair;
   logic      [7:0]  flags_nxt;
   logic             push;
   logic             pop;
   logic      [15:0] pc_seq;
   logic      [15:0] rel_ext;

   alu_flag_calc alu_flag_calc_i (
      .op_in     (instr_in.op),
      .a_in      (instr_in.dst),
      .b_in      ((instr_in.op == op_plus_regs || instr_in.op == op_plus_carry ||
                   instr_in.op == op_minus_regs || instr_in.op == op_minus_regs_borrow ||
                   instr_in.op == op_and_regs || instr_in.op == op_or_regs ||
                   instr_in.op == op_compare_with_borrow) ? instr_in.src_reg : instr_in.imm),
      .flags_in  (flags_r),
      .res_out   (alu_res),
      .flags_out (alu_flags),
      .write_out (alu_wr)
   );

   assign pair    = {instr_in.dst_hi, instr_in.dst};
   assign pc_seq  = pc_r + 16'h0001;
   assign rel_ext = {{4{instr_in.rel[11]}}, instr_in.rel};

   // word arithmetic on the high:low pair; only the low six bits of K reach the adder
   always_comb
   begin
      if (instr_in.op == op_word_imm_minus)
         word_sum = {1'b0, pair} - {11'h000, instr_in.imm[5:0]};
      else
         word_sum = {1'b0, pair} + {11'h000, instr_in.imm[5:0]};
   end

   // decode: cycle count, next pc, skip decision, flags and stack use
   always_comb
   begin
      cycles    = 3'(`CYC_ONE);
      target    = pc_seq;
      skip      = 1'b0;
      flags_nxt = alu_flags;
      push      = 1'b0;
      pop       = 1'b0;
      case (instr_in.op)
         op_word_imm_plus, op_word_imm_minus:
         begin
            cycles = 3'(`CYC_TWO);
            flags_nxt[`FLAG_Z] = (word_sum[15:0] == 16'h0000);
            flags_nxt[`FLAG_N] = word_sum[15];
            flags_nxt[`FLAG_C] = word_sum[16];
            flags_nxt[`FLAG_V] = (instr_in.op == op_word_imm_plus) ? (~pair[15] & word_sum[15])
                                                                    : (pair[15] & ~word_sum[15]);
            flags_nxt[`FLAG_S] = word_sum[15] ^ flags_nxt[`FLAG_V];
         end
         op_jump_via_pointer:
         begin
            cycles = 3'(`CYC_TWO);
            target = instr_in.z_ptr;
         end
         op_call_via_pointer:
         begin
            cycles = 3'(`CYC_THREE);
            target = instr_in.z_ptr;
            push   = 1'b1;
         end
         op_rel_call:
         begin
            cycles = 3'(`CYC_THREE);
            target = pc_seq + rel_ext;
            push   = 1'b1;
         end
         op_sub_exit, op_irq_exit:
         begin
            cycles = `CYC_EXIT;
            pop    = 1'b1;
            target = (sp_r != '0) ? stack_mem[SP_W'(sp_r - 1'b1)] : pc_seq;
            if (instr_in.op == op_irq_exit)
               flags_nxt[`FLAG_I] = 1'b1;
         end
         op_skip_if_equal:
            skip = (instr_in.dst == instr_in.src_reg);
         op_skip_reg_bit_low:
            skip = !instr_in.src_reg[instr_in.imm[2:0]];
         op_skip_reg_bit_high:
            skip = instr_in.src_reg[instr_in.imm[2:0]];
         op_skip_io_bit_low:
            skip = !instr_in.io_val[instr_in.imm[2:0]];
         op_skip_io_bit_high:
            skip = instr_in.io_val[instr_in.imm[2:0]];
         op_branch_flag_set:
         begin
            if (flags_r[instr_in.imm[2:0]])
            begin
               cycles = 3'(`CYC_TWO);
               target = pc_seq + rel_ext;
            end
         end
         default:
            cycles = 3'(`CYC_ONE);
      endcase
      // skipped instruction length sets the extra cycles
      if (skip)
      begin
         cycles = instr_in.next_two ? 3'(`CYC_THREE) : 3'(`CYC_TWO);
         target = instr_in.next_two ? pc_r + 16'h0003 : pc_r + 16'h0002;
      end
   end

   // sequencing: multi-cycle ops hold busy and finish after their count
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= st_idle;
         cnt_r   <= 3'h0;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         case (state_r)
            st_idle:
            begin
               if (start_in)
               begin
                  if (cycles == 3'(`CYC_ONE))
                     done_r <= 1'b1;
                  else
                  begin
                     state_r <= st_wait;
                     busy_r  <= 1'b1;
                     cnt_r   <= cycles - 3'h2;
                  end
               end
            end
            st_wait:
            begin
               if (cnt_r == 3'h0)
               begin
                  state_r <= st_idle;
                  busy_r  <= 1'b0;
                  done_r  <= 1'b1;
               end
               else
                  cnt_r <= cnt_r - 3'h1;
            end
            default:
               state_r <= st_idle;
         endcase
      end
   end

   // architectural effects are applied at issue; done marks when timing allows the next
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         pc_r        <= `PC_RESET;
         flags_r     <= 8'h00;
         result_r    <= '0;
      end
      else
      begin
         result_r.wr_lo <= 1'b0;
         result_r.wr_hi <= 1'b0;
         if (state_r == st_idle && start_in)
         begin
            pc_r    <= target;
            flags_r <= flags_nxt;
            if (instr_in.op == op_word_imm_plus || instr_in.op == op_word_imm_minus)
            begin
               result_r.lo    <= word_sum[7:0];
               result_r.hi    <= word_sum[15:8];
               result_r.wr_lo <= 1'b1;
               result_r.wr_hi <= 1'b1;
            end
            else if (alu_wr)
            begin
               result_r.lo    <= alu_res;
               result_r.wr_lo <= 1'b1;
            end
         end
      end
   end

   // return address stack
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         sp_r  <= '0;
         err_r <= 1'b0;
      end
      else if (state_r == st_idle && start_in)
      begin
         if (push)
         begin
            if (sp_r == (SP_W+1)'(STACK_DEPTH))
               err_r <= 1'b1;  // full: the oldest entry would be lost, so refuse
            else
            begin
               stack_mem[SP_W'(sp_r)] <= pc_seq;
               sp_r <= sp_r + 1'b1;
            end
         end
         else if (pop)
         begin
            if (sp_r == '0)
               err_r <= 1'b1;
            else
               sp_r <= sp_r - 1'b1;
         end
      end
   end

   assign busy_out      = busy_r;
   assign done_out      = done_r;
   assign result_out    = result_r;
   assign flags_out     = flags_r;
   assign pc_out        = pc_r;
   assign stack_err_out = err_r;

   // assertions
   one_cycle_ops_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_plus_regs) |=> done_r && !busy_r)
      else $error("register sum did not finish in one cycle");
   word_two_cycle_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_word_imm_plus) |=> busy_r ##1 done_r)
      else $error("word add did not take two cycles");
   word_minus_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_word_imm_minus)
      |=> {result_r.hi, result_r.lo} == $past(pair) - {10'h000, $past(instr_in.imm[5:0])})
      else $error("word subtract result wrong");
   jump_pointer_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_jump_via_pointer)
      |=> pc_r == $past(instr_in.z_ptr) && busy_r ##1 done_r)
      else $error("jump via pointer wrong");
   call_three_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_call_via_pointer)
      |=> busy_r ##1 busy_r ##1 done_r)
      else $error("call via pointer did not take three cycles");
   skip_equal_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_skip_if_equal &&
       instr_in.dst == instr_in.src_reg && !instr_in.next_two)
      |=> pc_r == $past(pc_r) + 16'h0002 && flags_r == $past(flags_r))
      else $error("skip if equal wrong");
   compare_keeps_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_compare_imm) |=> !result_r.wr_lo)
      else $error("compare stored a result");
   branch_taken_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_branch_flag_set &&
       flags_r[instr_in.imm[2:0]]) |=> pc_r == $past(pc_seq + rel_ext) ##1 done_r)
      else $error("flag branch wrong");
   logic_flags_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_mask_imm)
      |=> flags_r[`FLAG_C] == $past(flags_r[`FLAG_C]) && !flags_r[`FLAG_V])
      else $error("logic op touched carry or set overflow");
   irq_exit_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_irq_exit) |=> flags_r[`FLAG_I])
      else $error("interrupt exit did not set I");
   borrow_minus_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_minus_regs_borrow)
      |=> result_r.wr_lo &&
          result_r.lo == $past(instr_in.dst) - $past(instr_in.src_reg) - {7'h00, $past(flags_r[`FLAG_C])})
      else $error("borrow difference result wrong");
   clear_mask_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_clear_mask_bits)
      |=> result_r.wr_lo && result_r.lo == ($past(instr_in.dst) & ~$past(instr_in.imm)))
      else $error("clear mask bits result wrong");
   word_sign_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_word_imm_plus)
      |=> {result_r.hi, result_r.lo} == $past(pair) + {10'h000, $past(instr_in.imm[5:0])} &&
          flags_r[`FLAG_S] == (flags_r[`FLAG_N] ^ flags_r[`FLAG_V]))
      else $error("word add result or sign flag wrong");
   skip_three_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_skip_reg_bit_high &&
       instr_in.src_reg[instr_in.imm[2:0]] && instr_in.next_two)
      |=> pc_r == $past(pc_r) + 16'h0003 && busy_r ##1 busy_r ##1 done_r)
      else $error("two-word skip wrong");
   io_skip_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_skip_io_bit_high &&
       instr_in.io_val[instr_in.imm[2:0]] && !instr_in.next_two)
      |=> pc_r == $past(pc_r) + 16'h0002 && busy_r ##1 done_r)
      else $error("io bit skip wrong");
   branch_idle_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_branch_flag_set &&
       !flags_r[instr_in.imm[2:0]]) |=> pc_r == $past(pc_r) + 16'h0001 && done_r && !busy_r)
      else $error("untaken flag branch wrong");
   call_push_a : assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == st_idle && start_in && instr_in.op == op_call_via_pointer && sp_r == '0)
      |=> sp_r == (SP_W+1)'(1) && stack_mem[0] == $past(pc_r) + 16'h0001)
      else $error("call did not push its return address");
   skip_cover_c : cover property (@(posedge core_clk_in) state_r == st_idle && start_in && skip);
   call_cover_c : cover property (@(posedge core_clk_in) state_r == st_idle && start_in && push);
   exit_cover_c : cover property (@(posedge core_clk_in) state_r == st_idle && start_in && pop && sp_r != '0);
   branch_cover_c : cover property (@(posedge core_clk_in)
      state_r == st_idle && start_in && instr_in.op == op_branch_flag_set && cycles == 3'(`CYC_TWO));
   err_cover_c : cover property (@(posedge core_clk_in) state_r == st_idle && start_in && pop && sp_r == '0);
endmodule : alu_branch_exec_unit

// ---- hw/alu_exec_pkg.sv ----
// types for the alu and branch execution unit
package alu_exec_pkg;
   typedef enum logic [4:0] {
      op_nop, op_plus_regs, op_plus_carry, op_word_imm_plus, op_minus_regs, op_minus_imm,
      op_minus_regs_borrow, op_minus_imm_borrow, op_word_imm_minus, op_and_regs, op_mask_imm,
      op_or_regs, op_union_imm, op_set_mask_bits, op_clear_mask_bits, op_zero_minus_test,
      op_jump_via_pointer, op_call_via_pointer, op_rel_call, op_sub_exit, op_irq_exit,
      op_skip_if_equal, op_compare_imm, op_compare_with_borrow, op_skip_reg_bit_low,
      op_skip_reg_bit_high, op_skip_io_bit_low, op_skip_io_bit_high, op_branch_flag_set
   } op_t;
   typedef struct packed {
      op_t         op;
      logic [7:0]  dst;      // destination or low byte of pair
      logic [7:0]  dst_hi;   // high byte of pair
      logic [7:0]  src_reg;  // source register value
      logic [7:0]  imm;      // constant, or bit number in [2:0], flag in [2:0]
      logic [7:0]  io_val;   // io register value for io bit skips
      logic [11:0] rel;      // signed relative offset k
      logic [15:0] z_ptr;    // Z pointer pair
      logic        next_two; // following instruction is two words
   } instr_t;
   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic       wr_lo;
      logic       wr_hi;
   } result_t;
endpackage : alu_exec_pkg

// ---- hw/alu_exec_regs.svh ----
// constants for the alu and branch execution unit
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define CYC_ONE 2'd1
`define CYC_TWO 2'd2
`define CYC_THREE 2'd3
`define CYC_EXIT 3'd4
`define FF_MASK 8'hff
`define PC_RESET 16'h0000
`define SP_RESET 8'hff
`endif

// ---- hw/alu_flag_calc.sv ----
// 8-bit arithmetic and logic with flag generation
`timescale 1ns/100ps
`include "alu_exec_regs.svh"
module alu_flag_calc
   import alu_exec_pkg::*;
(
   input  wire op_t        op_in,
   input  wire logic [7:0] a_in,
   input  wire logic [7:0] b_in,
   input  wire logic [7:0] flags_in,
   output logic      [7:0] res_out,
   output logic      [7:0] flags_out,
   output logic            write_out
);
   logic [8:0] sum;
   logic [4:0] half;
   logic       cin;
   logic       is_sub;
   logic       is_logic;
   logic       keep_z;
   // one shared adder serves sums, differences and compares
   always_comb
   begin
      cin      = 1'b0;
      is_sub   = 1'b0;
      is_logic = 1'b0;
      keep_z   = 1'b0;
      write_out = 1'b1;
      sum      = 9'h000;
      half     = 5'h00;
      res_out  = a_in;
      case (op_in)
         op_plus_regs, op_plus_carry:
         begin
            cin  = (op_in == op_plus_carry) ? flags_in[`FLAG_C] : 1'b0;
            sum  = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin};
            half = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, cin};
            res_out = sum[7:0];
         end
         op_minus_regs, op_minus_imm, op_minus_regs_borrow, op_minus_imm_borrow, op_compare_imm,
         op_compare_with_borrow:
         begin
            is_sub = 1'b1;
            cin    = (op_in == op_minus_regs_borrow || op_in == op_minus_imm_borrow ||
                      op_in == op_compare_with_borrow) ? flags_in[`FLAG_C] : 1'b0;
            keep_z = (cin == 1'b1) || (op_in == op_compare_with_borrow);
            sum    = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin};
            half   = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, cin};
            res_out = sum[7:0];
            write_out = !(op_in == op_compare_imm || op_in == op_compare_with_borrow);
         end
         op_and_regs, op_mask_imm:
         begin
            is_logic = 1'b1;
            res_out  = a_in & b_in;
         end
         op_or_regs, op_union_imm, op_set_mask_bits:
         begin
            is_logic = 1'b1;
            res_out  = a_in | b_in;
         end
         op_clear_mask_bits:
         begin
            is_logic = 1'b1;
            res_out  = a_in & (`FF_MASK - b_in);
         end
         op_zero_minus_test:
         begin
            is_logic = 1'b1;
            res_out  = a_in & a_in;
         end
         default:
            write_out = 1'b0;
      endcase
   end
   // flag update; logic ops touch only Z, N and V
   always_comb
   begin
      flags_out = flags_in;
      if (is_logic)
      begin
         flags_out[`FLAG_Z] = (res_out == 8'h00);
         flags_out[`FLAG_N] = res_out[7];
         flags_out[`FLAG_V] = 1'b0;
      end
      else if (write_out || op_in == op_compare_imm || op_in == op_compare_with_borrow)
      begin
         // borrow forms with carry in set, and compare with borrow, keep Z clear when the upper byte chain is nonzero
         flags_out[`FLAG_Z] = keep_z ? ((res_out == 8'h00) & flags_in[`FLAG_Z]) : (res_out == 8'h00);
         flags_out[`FLAG_C] = sum[8];
         flags_out[`FLAG_N] = res_out[7];
         flags_out[`FLAG_H] = half[4];
         flags_out[`FLAG_V] = is_sub ? ((a_in[7] ^ b_in[7]) & (a_in[7] ^ res_out[7]))
                                     : (~(a_in[7] ^ b_in[7]) & (a_in[7] ^ res_out[7]));
      end
   end
endmodule : alu_flag_calc

// ---- tb/alu_branch_exec_unit_tb.sv ----
// self-checking bench for the alu and branch execution unit
`timescale 1ns/100ps
module alu_branch_exec_unit_tb
   import alu_exec_pkg::*;
();
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        start = 1'b0;
   instr_t      instr = '0;
   logic        busy;
   logic        done;
   logic        err;
   result_t     res;
   result_t     res_q;
   logic [7:0]  flags;
   logic [15:0] pc;
   int          mismatches = 0;
   int          checked = 0;
   int          cycles = 0;
   int          n_seen;

   alu_branch_exec_unit alu_branch_exec_unit_i (
      .core_clk_in   (clk),
      .rst_n_in      (rst_n),
      .start_in      (start),
      .instr_in      (instr),
      .busy_out      (busy),
      .done_out      (done),
      .result_out    (res),
      .flags_out     (flags),
      .pc_out        (pc),
      .stack_err_out (err)
   );

   // 250 MHz core clock
   always #2 clk = ~clk;

   task automatic results();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   // cut a hang short well beyond the hundred or so cycles the tests need
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         $display("[ERR] %0t timeout", $time);
         results();
      end
   end

   // masked compare; a masked-in unknown never matches
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
      checked++;
      if ((got & mask) !== (exp & mask))
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got & mask, exp & mask);
      end
   endtask : cmp

   function automatic instr_t mk(input op_t op, input logic [7:0] d, input logic [7:0] s,
                                 input logic [7:0] k, input logic [11:0] r, input logic [15:0] z,
                                 input logic two);
      instr_t i;
      i = '0;
      i.op = op;
      i.dst = d;
      i.src_reg = s;
      i.imm = k;
      i.io_val = d;
      i.rel = r;
      i.z_ptr = z;
      i.next_two = two;
      return i;
   endfunction : mk

   // issue one instruction; write-back is caught the cycle after issue, then done is awaited
   task automatic exec(input instr_t ins, input int n);
      @(posedge clk);
      instr <= ins;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      res_q = res;
      cmp({15'h0000, busy}, {15'h0000, n > 1}, 16'h0001);
      n_seen = 1;
      while (done !== 1'b1 && n_seen < 8)
      begin
         @(posedge clk);
         #1;
         n_seen++;
      end
      cmp(16'(n_seen), 16'(n), 16'hffff);
   endtask : exec

   // arithmetic and logic: write strobes, written bytes, updated flags
   task automatic alu(input op_t op, input logic [7:0] d, input logic [7:0] dh, input logic [7:0] b,
                      input int n, input logic [1:0] wr, input logic [15:0] r,
                      input logic [7:0] fm, input logic [7:0] fe);
      instr_t ins;
      ins = mk(op, d, b, b, 12'h000, 16'h0000, 1'b0);
      ins.dst_hi = dh;
      exec(ins, n);
      cmp({14'h0000, res_q.wr_hi, res_q.wr_lo}, {14'h0000, wr}, 16'h0003);
      cmp({res_q.hi, res_q.lo}, r, {{8{wr[1]}}, {8{wr[0]}}});
      cmp({8'h00, flags}, {8'h00, fe}, {8'h00, fm});
   endtask : alu

   // flow control: cycle count and, where predictable, the new pc
   task automatic br(input op_t op, input logic [7:0] a, input logic [7:0] b, input logic [11:0] r,
                     input logic [15:0] z, input logic two, input int n, input logic chk,
                     input logic [15:0] pcx);
      exec(mk(op, a, (op == op_skip_if_equal) ? b : a, b, r, z, two), n);
      cmp(pc, pcx, {16{chk}});
   endtask : br

   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      cmp(pc, 16'h0000, 16'hffff);
      cmp({8'h00, flags}, 16'h0000, 16'hffff);
      cmp({13'h0000, busy, done, err}, 16'h0000, 16'hffff);
      // c and h from the overflowing sum stay put through the logic ops
      alu(op_plus_regs, 8'h0f, 8'h00, 8'h01, 1, 2'b01, 16'h0010, 8'h2f, 8'h20);
      alu(op_plus_regs, 8'hff, 8'h00, 8'h01, 1, 2'b01, 16'h0000, 8'h2f, 8'h23);
      alu(op_and_regs, 8'hf0, 8'h00, 8'h0f, 1, 2'b01, 16'h0000, 8'h2f, 8'h23);
      alu(op_mask_imm, 8'h8f, 8'h00, 8'hf0, 1, 2'b01, 16'h0080, 8'h2f, 8'h25);
      alu(op_or_regs, 8'h80, 8'h00, 8'h01, 1, 2'b01, 16'h0081, 8'h2f, 8'h25);
      alu(op_union_imm, 8'h00, 8'h00, 8'h00, 1, 2'b01, 16'h0000, 8'h2f, 8'h23);
      alu(op_set_mask_bits, 8'h10, 8'h00, 8'h0c, 1, 2'b01, 16'h001c, 8'h2f, 8'h21);
      alu(op_clear_mask_bits, 8'hff, 8'h00, 8'h0f, 1, 2'b01, 16'h00f0, 8'h2f, 8'h25);
      alu(op_zero_minus_test, 8'h85, 8'h00, 8'h00, 1, 2'b01, 16'h0085, 8'h2f, 8'h25);
      alu(op_plus_carry, 8'h7f, 8'h00, 8'h00, 1, 2'b01, 16'h0080, 8'h2f, 8'h2c);
      alu(op_minus_regs, 8'h10, 8'h00, 8'h01, 1, 2'b01, 16'h000f, 8'h2f, 8'h20);
      alu(op_minus_imm, 8'h00, 8'h00, 8'h01, 1, 2'b01, 16'h00ff, 8'h2f, 8'h25);
      alu(op_minus_regs_borrow, 8'h05, 8'h00, 8'h04, 1, 2'b01, 16'h0000, 8'h2f, 8'h00);
      alu(op_word_imm_plus, 8'hff, 8'h7f, 8'h01, 2, 2'b11, 16'h8000, 8'h1f, 8'h0c);
      alu(op_word_imm_minus, 8'h00, 8'h00, 8'h01, 2, 2'b11, 16'hffff, 8'h1f, 8'h15);
      alu(op_compare_with_borrow, 8'h06, 8'h00, 8'h05, 1, 2'b00, 16'h0000, 8'h2f, 8'h00);
      alu(op_compare_imm, 8'h05, 8'h00, 8'h05, 1, 2'b00, 16'h0000, 8'h2f, 8'h02);
      alu(op_minus_imm_borrow, 8'h01, 8'h00, 8'h01, 1, 2'b01, 16'h0000, 8'h2f, 8'h02);
      // taken skips chain from a known pc; z stays 1 and c stays 0 from here on
      br(op_jump_via_pointer, 8'h00, 8'h00, 12'h000, 16'h1000, 1'b0, 2, 1'b1, 16'h1000);
      br(op_skip_if_equal, 8'h5a, 8'h5a, 12'h000, 16'h0000, 1'b0, 2, 1'b1, 16'h1002);
      br(op_skip_reg_bit_high, 8'h80, 8'h07, 12'h000, 16'h0000, 1'b1, 3, 1'b1, 16'h1005);
      br(op_skip_reg_bit_low, 8'hfe, 8'h00, 12'h000, 16'h0000, 1'b0, 2, 1'b1, 16'h1007);
      br(op_skip_io_bit_high, 8'h08, 8'h03, 12'h000, 16'h0000, 1'b0, 2, 1'b1, 16'h1009);
      br(op_skip_io_bit_low, 8'hf7, 8'h03, 12'h000, 16'h0000, 1'b1, 3, 1'b1, 16'h100c);
      br(op_skip_if_equal, 8'h5a, 8'h5b, 12'h000, 16'h0000, 1'b0, 1, 1'b0, 16'h0000);
      br(op_skip_reg_bit_high, 8'h7f, 8'h07, 12'h000, 16'h0000, 1'b0, 1, 1'b0, 16'h0000);
      br(op_skip_io_bit_low, 8'h08, 8'h03, 12'h000, 16'h0000, 1'b0, 1, 1'b0, 16'h0000);
      br(op_skip_io_bit_high, 8'hf7, 8'h03, 12'h000, 16'h0000, 1'b0, 1, 1'b0, 16'h0000);
      br(op_branch_flag_set, 8'h00, 8'h00, 12'h010, 16'h0000, 1'b0, 1, 1'b0, 16'h0000);
      br(op_jump_via_pointer, 8'h00, 8'h00, 12'h000, 16'h1000, 1'b0, 2, 1'b1, 16'h1000);
      br(op_branch_flag_set, 8'h00, 8'h01, 12'h010, 16'h0000, 1'b0, 2, 1'b1, 16'h1011);
      br(op_branch_flag_set, 8'h00, 8'h01, 12'hffe, 16'h0000, 1'b0, 2, 1'b1, 16'h1010);
      cmp({8'h00, flags}, 16'h0012, 16'h003f);
      // nested call and returns, then one pop too many
      br(op_jump_via_pointer, 8'h00, 8'h00, 12'h000, 16'h1000, 1'b0, 2, 1'b1, 16'h1000);
      br(op_call_via_pointer, 8'h00, 8'h00, 12'h000, 16'h2000, 1'b0, 3, 1'b1, 16'h2000);
      br(op_rel_call, 8'h00, 8'h00, 12'h005, 16'h0000, 1'b0, 3, 1'b1, 16'h2006);
      br(op_irq_exit, 8'h00, 8'h00, 12'h000, 16'h0000, 1'b0, 4, 1'b1, 16'h2001);
      cmp({8'h00, flags}, 16'h0080, 16'h0080);
      br(op_sub_exit, 8'h00, 8'h00, 12'h000, 16'h0000, 1'b0, 4, 1'b1, 16'h1001);
      cmp({15'h0000, err}, 16'h0000, 16'h0001);
      br(op_sub_exit, 8'h00, 8'h00, 12'h000, 16'h0000, 1'b0, 4, 1'b1, 16'h1002);
      cmp({15'h0000, err}, 16'h0001, 16'h0001);
      results();
   end
endmodule : alu_branch_exec_unit_tb
